// ==== common/sorr_pkg.sv ====
// Constants and types for the stage output reset override block.
package sorr_pkg;

  // ****************************************************************
  // Configuration byte layout
  // ****************************************************************
  localparam int unsigned EXT_CFG_W           = 8;
  localparam int unsigned CFG_OVR_EN_POS      = 5;
  localparam int unsigned CFG_A_LEVEL_POS     = 4;
  localparam int unsigned CFG_B_LEVEL_POS     = 3;
  localparam logic [7:0]  EXT_CFG_DEFAULT     = 8'hff;
  localparam logic        CFG_PROGRAMMED      = 1'b0;
  localparam int unsigned NUM_CHANNELS        = 3;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] ADDR_EXT_CFG        = 12'h000;
  localparam logic [11:0] ADDR_OUT_CFG        = 12'h004;
  localparam logic [11:0] ADDR_OVR_STATUS     = 12'h008;
  localparam logic [11:0] ADDR_PORT_DATA      = 12'h00c;
  localparam int unsigned OUT_CFG_W           = 8;
  localparam logic [7:0]  OUT_CFG_RESET       = 8'h00;
  localparam logic [5:0]  PORT_DATA_RESET     = 6'h00;
  localparam logic [31:0] APB_ZERO            = 32'h0000_0000;

  // Output state of the forced pins of both sides.
  typedef struct packed {
    logic       active;
    logic       a_level;
    logic       b_level;
  } sorr_force_t;

endpackage

// ==== hdl/sorr_top.sv ====
// Stage output reset override with APB register access.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

module sorr_top
  import sorr_pkg::*;
(
  // Clock and reset
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST_N,
  // Non-volatile configuration byte, static while powered
  input  wire logic [EXT_CFG_W-1:0]    EXT_CFG,
  // Waveform generator outputs per channel
  input  wire logic [NUM_CHANNELS-1:0] GEN_A,
  input  wire logic [NUM_CHANNELS-1:0] GEN_B,
  // Stage output pins
  output logic      [NUM_CHANNELS-1:0] STAGE_OUT_A,
  output logic      [NUM_CHANNELS-1:0] STAGE_OUT_B,
  output logic      [NUM_CHANNELS-1:0] STAGE_OE_A,
  output logic      [NUM_CHANNELS-1:0] STAGE_OE_B,
  // APB slave
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [11:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR
);

  // ****************************************************************
  // Local types
  // ****************************************************************
  // Capture of the configuration byte after reset release. The byte
  // passes two stages before the held copy is loaded from it.
  typedef enum logic [1:0] {
    CAP_RESET,
    CAP_STAGE1,
    CAP_STAGE2,
    CAP_DONE
  } sorr_cap_state_t;

  // Lifecycle of the forced output state after reset.
  typedef enum logic {
    OVR_ARMED,
    OVR_RELEASED
  } sorr_ovr_state_t;

  // ****************************************************************
  // Signals
  // ****************************************************************
  sorr_cap_state_t      cap_state;
  sorr_cap_state_t      next_cap_state;
  sorr_ovr_state_t      ovr_state;
  sorr_ovr_state_t      next_ovr_state;
  logic [EXT_CFG_W-1:0] cfg_sync1;
  logic [EXT_CFG_W-1:0] cfg_sync2;
  logic [EXT_CFG_W-1:0] cfg_held;
  logic [OUT_CFG_W-1:0] out_cfg;
  logic [5:0]           port_data;
  sorr_force_t          force_sel;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic is_programmed(input logic b);
    return (b == CFG_PROGRAMMED);
  endfunction

  // Per-channel choice between generator and port data, for one side.
  function automatic logic [NUM_CHANNELS-1:0] pick_source(
    input logic [NUM_CHANNELS-1:0] use_gen,
    input logic [NUM_CHANNELS-1:0] gen,
    input logic [NUM_CHANNELS-1:0] port
  );
    return (use_gen & gen) | (~use_gen & port);
  endfunction

  // A pin is driven when its own bit or the side-wide enable is set.
  function automatic logic [NUM_CHANNELS-1:0] side_enable(
    input logic [NUM_CHANNELS-1:0] chan_en,
    input logic                    all_en
  );
    return chan_en | {NUM_CHANNELS{all_en}};
  endfunction

  // Places a register image in the low byte of a bus word.
  function automatic logic [31:0] to_word(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire apb_xfer     = PSEL & PENABLE;
  wire apb_wr       = apb_xfer & PWRITE;
  wire apb_rd_setup = PSEL & ~PENABLE & ~PWRITE;
  wire hit_cfg      = (PADDR == ADDR_EXT_CFG);
  wire hit_out      = (PADDR == ADDR_OUT_CFG);
  wire hit_stat     = (PADDR == ADDR_OVR_STATUS);
  wire hit_port     = (PADDR == ADDR_PORT_DATA);
  wire hit_any      = hit_cfg | hit_out | hit_stat | hit_port;
  wire wr_out_cfg   = apb_wr & hit_out;
  wire wr_port      = apb_wr & hit_port;

  // ****************************************************************
  // Configuration sampling
  // ****************************************************************
  // The byte is a static level from the non-volatile array. While reset
  // is held, and until the held copy is loaded, the raw byte steers the
  // outputs, so the forced state appears at reset entry rather than a
  // clock later; the price is that the byte must not move in reset.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cfg_sync1 <= EXT_CFG_DEFAULT;
      cfg_sync2 <= EXT_CFG_DEFAULT;
    end else begin
      cfg_sync1 <= EXT_CFG;
      cfg_sync2 <= cfg_sync1;
    end
  end

  always_comb begin
    next_cap_state = cap_state;
    case (cap_state)
      CAP_RESET: begin
        next_cap_state = CAP_STAGE1;
      end
      CAP_STAGE1: begin
        next_cap_state = CAP_STAGE2;
      end
      CAP_STAGE2: begin
        next_cap_state = CAP_DONE;
      end
      CAP_DONE: begin
        next_cap_state = CAP_DONE;
      end
      default: begin
        next_cap_state = CAP_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cap_state <= CAP_RESET;
    end else begin
      cap_state <= next_cap_state;
    end
  end

  // The held copy is loaded once, when the second stage first holds a
  // sample taken out of reset; loading earlier would pick up the reset
  // value of the stages and drop the override for good.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cfg_held <= EXT_CFG_DEFAULT;
    end else if (cap_state == CAP_STAGE2) begin
      cfg_held <= cfg_sync2;
    end
  end

  wire                 cfg_valid = (cap_state == CAP_DONE);
  wire [EXT_CFG_W-1:0] cfg_now   = cfg_valid ? cfg_held : EXT_CFG;

  // ****************************************************************
  // Override selection
  // ****************************************************************
  always_comb begin
    force_sel.active  = is_programmed(cfg_now[CFG_OVR_EN_POS]);
    force_sel.a_level = is_programmed(cfg_now[CFG_A_LEVEL_POS]);
    force_sel.b_level = is_programmed(cfg_now[CFG_B_LEVEL_POS]);
  end

  always_comb begin
    next_ovr_state = ovr_state;
    case (ovr_state)
      OVR_ARMED: begin
        if (wr_out_cfg) begin
          next_ovr_state = OVR_RELEASED;
        end
      end
      OVR_RELEASED: begin
        next_ovr_state = OVR_RELEASED;
      end
      default: begin
        next_ovr_state = OVR_ARMED;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ovr_state <= OVR_ARMED;
    end else begin
      ovr_state <= next_ovr_state;
    end
  end

  // Release comes with any write to the output configuration register,
  // even one that repeats the reset value.
  wire written = (ovr_state == OVR_RELEASED);
  wire forcing = force_sel.active & ~written;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      out_cfg <= OUT_CFG_RESET;
    end else if (wr_out_cfg) begin
      out_cfg <= PWDATA[OUT_CFG_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      port_data <= PORT_DATA_RESET;
    end else if (wr_port) begin
      port_data <= PWDATA[5:0];
    end
  end

  // ****************************************************************
  // Output steering
  // ****************************************************************
  wire [NUM_CHANNELS-1:0] gen_sel_a = out_cfg[2:0];
  wire [NUM_CHANNELS-1:0] gen_sel_b = out_cfg[5:3];
  wire                    oe_all_a  = out_cfg[6];
  wire                    oe_all_b  = out_cfg[7];

  wire [NUM_CHANNELS-1:0] norm_a =
    pick_source(gen_sel_a, GEN_A, port_data[2:0]);
  wire [NUM_CHANNELS-1:0] norm_b =
    pick_source(gen_sel_b, GEN_B, port_data[5:3]);
  wire [NUM_CHANNELS-1:0] norm_oe_a = side_enable(gen_sel_a, oe_all_a);
  wire [NUM_CHANNELS-1:0] norm_oe_b = side_enable(gen_sel_b, oe_all_b);

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  // Forced pins are driven from reset entry; the path from the static
  // configuration byte is glitch free since its inputs do not toggle.
  assign STAGE_OUT_A = forcing ? {NUM_CHANNELS{force_sel.a_level}}
                               : norm_a;
  assign STAGE_OUT_B = forcing ? {NUM_CHANNELS{force_sel.b_level}}
                               : norm_b;
  assign STAGE_OE_A  = forcing ? {NUM_CHANNELS{1'b1}}
                               : norm_oe_a;
  assign STAGE_OE_B  = forcing ? {NUM_CHANNELS{1'b1}}
                               : norm_oe_b;

  // ****************************************************************
  // APB read path
  // ****************************************************************
  // Read data is taken in the setup cycle, so it stands throughout the
  // access phase with no wait state.
  wire [2:0]  status_img = {written, forcing, force_sel.active};
  wire [31:0] rd_cfg     = to_word(cfg_now);
  wire [31:0] rd_out     = to_word(out_cfg);
  wire [31:0] rd_stat    = to_word({5'h00, status_img});
  wire [31:0] rd_port    = to_word({2'h0, port_data});

  wire [31:0] rd_mux =
    hit_cfg  ? rd_cfg  :
    hit_out  ? rd_out  :
    hit_stat ? rd_stat :
    hit_port ? rd_port : APB_ZERO;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= APB_ZERO;
    end else if (apb_rd_setup) begin
      PRDATA <= rd_mux;
    end
  end

  // ****************************************************************
  // APB handshake
  // ****************************************************************
  // Every register answers at once, so the access phase never waits.
  // Writes to the configuration byte and to unmapped offsets are
  // dropped; only the latter raise the error response.
  assign PREADY  = 1'b1;
  assign PSLVERR = apb_xfer & ~hit_any;

endmodule

// ==== sim/sorr_props.sv ====
// Port checks for the stage output reset override block.
`timescale 1ns/100ps
module sorr_props
  import sorr_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic [7:0]  EXT_CFG,
  input wire logic [2:0]  STAGE_OUT_A,
  input wire logic [2:0]  STAGE_OUT_B,
  input wire logic [2:0]  STAGE_OE_A,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA
);
  logic wr;
  wire  wacc = PSEL && PENABLE && PWRITE && PADDR == ADDR_OUT_CFG;
  wire  hold = !EXT_CFG[5] && !wr;
  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N) wr <= 1'b0;
    else if (wacc) wr <= 1'b1;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_rd; PSEL && !PENABLE && !PWRITE && PADDR == 12'h000; endsequence
  property p_rd_lo; s_rd |=> PRDATA[7:0] == EXT_CFG; endproperty
  property p_rd_hi; s_rd |=> PRDATA[31:8] == 24'h0; endproperty
  property p_port; EXT_CFG[5] && !wr |-> STAGE_OE_A == 3'h0; endproperty
  property p_force; hold |-> STAGE_OE_A == 3'h7; endproperty
  property p_rel;
    wacc |=> STAGE_OE_A == ($past(PWDATA[2:0]) | {3{$past(PWDATA[6])}});
  endproperty
  property p_lvl_a; hold |-> STAGE_OUT_A == {3{~EXT_CFG[4]}}; endproperty
  property p_lvl_b; hold |-> STAGE_OUT_B == {3{~EXT_CFG[3]}}; endproperty
  property p_calm;
    hold && !wacc |=> $stable(STAGE_OUT_A) && $stable(STAGE_OUT_B);
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("cfg read");
  a_rd_hi: assert property (p_rd_hi) else $error("cfg width");
  a_port: assert property (p_port) else $error("port oe");
  a_force: assert property (p_force) else $error("force oe");
  a_rel: assert property (p_rel) else $error("release");
  a_lvl_a: assert property (p_lvl_a) else $error("a level");
  a_lvl_b: assert property (p_lvl_b) else $error("b level");
  a_calm: assert property (p_calm) else $error("glitch");
endmodule
bind sorr_top sorr_props i_sorr_props (.CLK_SYS, .RST_N, .EXT_CFG,
  .STAGE_OUT_A, .STAGE_OUT_B, .STAGE_OE_A, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PRDATA);

// ==== sim/sorr_load.sv ====
// Power switch gate inputs seen at the stage pins.
`timescale 1ns/100ps
module sorr_load (
  input  wire logic [5:0] drv,
  input  wire logic [5:0] oe,
  output logic      [5:0] gate
);
  // Gate pull-downs keep a floating pin's switch off.
  assign gate = drv & oe;
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the stage output reset override block.
`timescale 1ns/100ps
module tb_top;
  import sorr_pkg::*;
  logic        CLK_SYS = 1'b0, RST_N = 1'b0, PSEL = 1'b0;
  logic        PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR, err;
  logic [7:0]  EXT_CFG = 8'hff;
  logic [2:0]  GEN_A = 3'h0, GEN_B = 3'h0;
  logic [2:0]  STAGE_OUT_A, STAGE_OUT_B, STAGE_OE_A, STAGE_OE_B;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [5:0]  gate;
  logic [7:0]  cfgs [5] = '{8'hff, 8'hdf, 8'hcf, 8'hd7, 8'hc7};
  int          mismatches = 0, comparisons = 0;
  always #2 CLK_SYS = ~CLK_SYS;
  sorr_top i_sorr_top (.CLK_SYS, .RST_N, .EXT_CFG, .GEN_A, .GEN_B,
    .STAGE_OUT_A, .STAGE_OUT_B, .STAGE_OE_A, .STAGE_OE_B, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);
  sorr_load i_sorr_load (.drv({STAGE_OUT_B, STAGE_OUT_A}),
    .oe({STAGE_OE_B, STAGE_OE_A}), .gate);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic run_cfg(input logic [7:0] cfg);
    logic [5:0] fz;
    fz = cfg[5] ? 6'h00 : {{3{~cfg[3]}}, {3{~cfg[4]}}};
    RST_N <= 1'b0;
    EXT_CFG <= cfg;
    repeat (10) @(posedge CLK_SYS);
    chk(32'(gate), 32'(fz));
    RST_N <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    GEN_A <= 3'h5;
    GEN_B <= 3'h3;
    apb(1'b1, ADDR_EXT_CFG, 32'h0);
    chk(32'(gate), 32'(fz));
    apb(1'b0, ADDR_EXT_CFG, 32'h0);
    chk(rd, {24'h0, cfg});
    apb(1'b1, ADDR_OUT_CFG, 32'hff);
    chk(32'(gate), {26'h0, GEN_B, GEN_A});
  endtask
  task automatic port_mode;
    apb(1'b1, ADDR_PORT_DATA, 32'h2c);
    apb(1'b1, ADDR_OUT_CFG, 32'hc0);
    chk(32'(gate), 32'h2c);
    apb(1'b0, ADDR_OVR_STATUS, 32'h0);
    chk(rd, 32'h5);
  endtask
  task automatic unmapped;
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    finish_test();
  end
  initial begin
    foreach (cfgs[i]) run_cfg(cfgs[i]);
    port_mode();
    unmapped();
    finish_test();
  end
endmodule
